// ---- rtl/game_rule_map.svh ----
// constants for the ball game rule controller
`ifndef GAME_RULE_MAP_SVH
`define GAME_RULE_MAP_SVH

`define CLK_PERIOD_PS    5000
`define DEBOUNCE_NS      20000
`define DEBOUNCE_CYCLES  ((`DEBOUNCE_NS * 1000) / `CLK_PERIOD_PS)
`define SCAN_NS          1000
`define SCAN_CYCLES      ((`SCAN_NS * 1000) / `CLK_PERIOD_PS)

`define COURT_MID        8'h80
`define KEEPER_LEFT_X    8'h10
`define KEEPER_RIGHT_X   8'hF0
`define BARRIER_STEP     8'h50
`define SCORE_MAX        4'hF
`define SERVE_ROTATE     3'h5
`define LFSR_SEED        8'h01

`endif

// ---- rtl/game_rule_pkg.sv ----
// types shared by the ball game rule controller
package game_rule_pkg;
    typedef enum logic [3:0] {
        GAME_NONE, GAME_TENNIS, GAME_HOCKEY, GAME_SQUASH, GAME_PRACTICE, GAME_SOCCER,
        GAME_BASKETBALL, GAME_BASKET_PRACTICE, GAME_GRIDBALL, GAME_TARGET_ONE, GAME_TARGET_TWO
    } game_t;
    typedef enum logic [1:0] {
        ST_WAIT, ST_PLAY, ST_OVER
    } play_state_t;
endpackage

// ---- rtl/sync_debounce.sv ----
// button synchroniser and debouncer with press pulse
`timescale 1ns/1ps
module sync_debounce #(
    parameter int WIDTH = 4,
    parameter int COUNT = 4000
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] rawN,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] press
);
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            logic        meta_reg, sync_reg, level_reg, press_reg;
            logic        level_next, press_next;
            logic [12:0] cnt_reg, cnt_next;
            always_comb begin
                cnt_next   = 13'h0000;
                level_next = level_reg;
                press_next = 1'b0;
                if (sync_reg != level_reg) begin
                    cnt_next = cnt_reg + 13'h0001;
                    if (cnt_reg == 13'(COUNT - 1)) begin
                        cnt_next   = 13'h0000;
                        level_next = sync_reg;
                        press_next = sync_reg;
                    end
                end
            end
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    meta_reg  <= 1'b0;
                    sync_reg  <= 1'b0;
                    level_reg <= 1'b0;
                    press_reg <= 1'b0;
                    cnt_reg   <= 13'h0000;
                end else begin
                    meta_reg  <= ~rawN[b];
                    sync_reg  <= meta_reg;
                    level_reg <= level_next;
                    press_reg <= press_next;
                    cnt_reg   <= cnt_next;
                end
            end
            assign level[b] = level_reg;
            assign press[b] = press_reg;
        end
    endgenerate
endmodule

// ---- rtl/lfsr_random.sv ----
// free running pseudo random source for serve angles
`timescale 1ns/1ps
`include "game_rule_map.svh"
module lfsr_random (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    output logic      [7:0] rnd
);
    logic [7:0] lfsr_reg, lfsr_next;
    // runs every cycle so the press instant picks the value
    always_comb begin
        lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lfsr_reg <= `LFSR_SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end
    assign rnd = lfsr_reg;
endmodule

// ---- rtl/ball_game_rule_control.sv ----
// game rules, service, scoring and game selection of the ball game
`timescale 1ns/1ps
`include "game_rule_map.svh"
module ball_game_rule_control
    import game_rule_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    output logic      [3:0]  strbOut,
    output logic      [3:0]  strbOe,
    input  wire logic [2:0]  selN,
    input  wire logic        serveLeftN,
    input  wire logic        serveRightN,
    input  wire logic        shotLeftN,
    input  wire logic        shotRightN,
    input  wire logic [7:0]  leftPosX,
    input  wire logic [7:0]  leftPosY,
    input  wire logic [7:0]  rightPosX,
    input  wire logic [7:0]  rightPosY,
    input  wire logic        hitLeft,
    input  wire logic        hitRight,
    input  wire logic        goalLeft,
    input  wire logic        goalRight,
    input  wire logic        basketMade,
    input  wire logic        targetStart,
    input  wire logic        onTargetLeft,
    input  wire logic        onTargetRight,
    output game_t            gameSel,
    output logic      [7:0]  leftBatX,
    output logic      [7:0]  leftBatY,
    output logic      [7:0]  rightBatX,
    output logic      [7:0]  rightBatY,
    output logic      [7:0]  leftKeeperY,
    output logic      [7:0]  rightKeeperY,
    output logic      [23:0] leftBarrierY,
    output logic      [23:0] rightBarrierY,
    output logic             launch,
    output logic             launchRight,
    output logic      [2:0]  launchAngle,
    output logic             ballAtServe,
    output logic             batsActive,
    output logic             ballColourRight,
    output logic             serverRight,
    output logic      [3:0]  scoreLeft,
    output logic      [3:0]  scoreRight,
    output logic             gameOver,
    output logic             winnerRight
);
    logic [3:0] btnPress;
    logic [7:0] rnd;

    sync_debounce #(.WIDTH(4), .COUNT(`DEBOUNCE_CYCLES)) u_buttons (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .rawN    ({shotRightN, shotLeftN, serveRightN, serveLeftN}),
        .level   (),
        .press   (btnPress)
    );

    lfsr_random u_random (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .rnd     (rnd)
    );

    wire logic pressL = btnPress[0];
    wire logic pressR = btnPress[1];
    wire logic shotL  = btnPress[2];
    wire logic shotR  = btnPress[3];

    // ---------------- game selection scan ----------------
    logic [15:0] scanCnt_reg, scanCnt_next;
    logic [1:0]  strbIdx_reg, strbIdx_next;
    game_t       game_reg, game_next;

    function automatic game_t decodeGame(input logic [1:0] idx, input logic [2:0] sel);
        game_t g;
        g = GAME_NONE;
        if (idx == 2'h0) begin
            if (!sel[0]) g = GAME_TENNIS;
            else if (!sel[1]) g = GAME_HOCKEY;
            else if (!sel[2]) g = GAME_SQUASH;
        end else if (idx == 2'h1) begin
            if (!sel[0]) g = GAME_PRACTICE;
            else if (!sel[1]) g = GAME_SOCCER;
            else if (!sel[2]) g = GAME_BASKETBALL;
        end else if (idx == 2'h2) begin
            if (!sel[0]) g = GAME_BASKET_PRACTICE;
            else if (!sel[1]) g = GAME_GRIDBALL;
        end else begin
            if (!sel[0]) g = GAME_TARGET_ONE;
            else if (!sel[1]) g = GAME_TARGET_TWO;
        end
        return g;
    endfunction

    // select lines are sampled at the end of each slot so they have settled
    always_comb begin
        scanCnt_next = scanCnt_reg + 16'h0001;
        strbIdx_next = strbIdx_reg;
        game_next    = game_reg;
        if (scanCnt_reg == 16'(`SCAN_CYCLES - 1)) begin
            scanCnt_next = 16'h0000;
            strbIdx_next = strbIdx_reg + 2'h1;
            if (decodeGame(strbIdx_reg, selN) != GAME_NONE) begin
                game_next = decodeGame(strbIdx_reg, selN);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scanCnt_reg <= 16'h0000;
            strbIdx_reg <= 2'h0;
            game_reg    <= GAME_NONE;
        end else begin
            scanCnt_reg <= scanCnt_next;
            strbIdx_reg <= strbIdx_next;
            game_reg    <= game_next;
        end
    end

    // open drain strobes: only the active one pulls low
    assign strbOut = 4'h0;
    assign strbOe  = 4'(1 << strbIdx_reg);
    assign gameSel = game_reg;
    wire logic gameChange = (game_next != game_reg);

    // ---------------- player positions ----------------
    logic [7:0]  lbx_next, rbx_next, lky_next, rky_next;
    logic [23:0] lbar_next, rbar_next;
    logic [7:0]  lbx_reg, rbx_reg, lby_reg, rby_reg, lky_reg, rky_reg;
    logic [23:0] lbar_reg, rbar_reg;

    always_comb begin
        lbx_next = leftPosX;
        rbx_next = rightPosX;
        lky_next = lky_reg;
        rky_next = rky_reg;
        if (game_reg == GAME_TENNIS) begin
            if (leftPosX >= `COURT_MID) lbx_next = `COURT_MID - 8'h01;
            if (rightPosX < `COURT_MID) rbx_next = `COURT_MID;
        end
        if (game_reg == GAME_HOCKEY || game_reg == GAME_SOCCER) begin
            lky_next = leftPosY;
            rky_next = rightPosY;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_barrier
            // each group follows the vertical control, spaced so the openings stagger
            assign lbar_next[g*8 +: 8] = (game_reg == GAME_GRIDBALL) ?
                8'(leftPosY + 8'(g) * `BARRIER_STEP) : lbar_reg[g*8 +: 8];
            assign rbar_next[g*8 +: 8] = (game_reg == GAME_GRIDBALL) ?
                8'(rightPosY + 8'(g) * `BARRIER_STEP) : rbar_reg[g*8 +: 8];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lbx_reg  <= 8'h00;
            rbx_reg  <= 8'h00;
            lby_reg  <= 8'h00;
            rby_reg  <= 8'h00;
            lky_reg  <= 8'h00;
            rky_reg  <= 8'h00;
            lbar_reg <= 24'h00_0000;
            rbar_reg <= 24'h00_0000;
        end else begin
            lbx_reg  <= lbx_next;
            rbx_reg  <= rbx_next;
            lby_reg  <= leftPosY;
            rby_reg  <= rightPosY;
            lky_reg  <= lky_next;
            rky_reg  <= rky_next;
            lbar_reg <= lbar_next;
            rbar_reg <= rbar_next;
        end
    end

    assign leftBatX      = lbx_reg;
    assign rightBatX     = rbx_reg;
    assign leftBatY      = lby_reg;
    assign rightBatY     = rby_reg;
    assign leftKeeperY   = lky_reg;
    assign rightKeeperY  = rky_reg;
    assign leftBarrierY  = lbar_reg;
    assign rightBarrierY = rbar_reg;

    // ---------------- rules, service and score ----------------
    play_state_t st_reg, st_next;
    logic [3:0] sl_reg, sl_next, sr_reg, sr_next;
    logic       srv_reg, srv_next, own_reg, own_next, armL_reg, armL_next, armR_reg, armR_next;
    logic       open_reg, open_next, win_reg, win_next, lau_reg, lau_next, lr_reg, lr_next;
    logic [2:0] ang_reg, ang_next, rot_reg, rot_next;
    logic       serveOk, rallyEnd, loserRight, twoPlayer, hitOkL, hitOkR;

    function automatic logic [3:0] inc4(input logic [3:0] v);
        return (v == `SCORE_MAX) ? v : v + 4'h1;
    endfunction

    always_comb begin
        st_next   = st_reg;
        sl_next   = sl_reg;
        sr_next   = sr_reg;
        srv_next  = srv_reg;
        own_next  = own_reg;
        armL_next = armL_reg | pressL;
        armR_next = armR_reg | pressR;
        open_next = open_reg;
        win_next  = win_reg;
        rot_next  = rot_reg;
        lau_next  = 1'b0;
        lr_next   = lr_reg;
        ang_next  = ang_reg;
        serveOk   = 1'b0;
        rallyEnd  = 1'b0;
        loserRight = goalRight;
        hitOkL    = 1'b0;
        hitOkR    = 1'b0;
        twoPlayer = game_reg inside {GAME_TENNIS, GAME_HOCKEY, GAME_SQUASH, GAME_SOCCER,
                                     GAME_BASKETBALL, GAME_GRIDBALL, GAME_TARGET_TWO};
        case (st_reg)
            ST_WAIT: begin
                case (game_reg)
                    GAME_TENNIS, GAME_SQUASH, GAME_SOCCER: serveOk = srv_reg ? pressR : pressL;
                    GAME_PRACTICE:                         serveOk = pressL | pressR;
                    GAME_HOCKEY, GAME_GRIDBALL, GAME_BASKETBALL: serveOk = armL_next & armR_next;
                    GAME_BASKET_PRACTICE:                  serveOk = pressR;
                    GAME_TARGET_ONE, GAME_TARGET_TWO:      st_next = ST_PLAY;
                    default:                               serveOk = 1'b0;
                endcase
                if (serveOk) begin
                    st_next  = ST_PLAY;
                    lau_next = 1'b1;
                    ang_next = rnd[2:0];
                    case (game_reg)
                        GAME_TENNIS, GAME_SOCCER: lr_next = ~srv_reg;
                        GAME_SQUASH, GAME_PRACTICE: lr_next = 1'b0;
                        default: lr_next = rnd[7];
                    endcase
                    own_next = ~srv_reg;
                    if (game_reg == GAME_PRACTICE) sl_next = inc4(sl_reg);
                end
            end
            ST_PLAY: begin
                case (game_reg)
                    GAME_SQUASH: begin
                        if (hitLeft | hitRight) begin
                            if ((hitRight && !own_reg) || (hitLeft && own_reg)) begin
                                rallyEnd   = 1'b1;
                                loserRight = hitRight;
                            end else begin
                                own_next = ~own_reg;
                            end
                        end else if (goalLeft | goalRight) begin
                            rallyEnd   = 1'b1;
                            loserRight = own_reg;
                        end
                    end
                    GAME_PRACTICE: begin
                        if (hitLeft | hitRight) sr_next = inc4(sr_reg);
                        if (goalLeft | goalRight) begin
                            sr_next = 4'h0;
                            st_next = ST_WAIT;
                        end
                    end
                    GAME_BASKET_PRACTICE: begin
                        if (basketMade) begin
                            sl_next = inc4(sl_reg);
                            sr_next = 4'h0;
                        end else if (hitLeft | hitRight) begin
                            sr_next = inc4(sr_reg);
                        end
                    end
                    GAME_TARGET_ONE, GAME_TARGET_TWO: begin
                        if (targetStart) begin
                            open_next = 1'b1;
                            if (game_reg == GAME_TARGET_ONE) sr_next = inc4(sr_reg);
                        end
                        // in GAME_TARGET_TWO simultaneous hits in the same cycle both score
                        hitOkL = open_reg & shotL & onTargetLeft;
                        hitOkR = open_reg & shotR & onTargetRight & (game_reg == GAME_TARGET_TWO);
                        if (hitOkL | hitOkR) begin
                            open_next = 1'b0;
                            if (hitOkL) sl_next = inc4(sl_reg);
                            if (hitOkR) sr_next = inc4(sr_reg);
                        end
                    end
                    default: begin
                        rallyEnd = goalLeft | goalRight;
                    end
                endcase
                if (rallyEnd) begin
                    st_next   = ST_WAIT;
                    armL_next = 1'b0;
                    armR_next = 1'b0;
                    if (game_reg == GAME_SQUASH) begin
                        if (loserRight == srv_reg) srv_next = ~srv_reg;
                        else if (loserRight) sl_next = inc4(sl_reg);
                        else sr_next = inc4(sr_reg);
                    end else begin
                        if (loserRight) sl_next = inc4(sl_reg);
                        else sr_next = inc4(sr_reg);
                        if (game_reg == GAME_SOCCER) srv_next = loserRight;
                        if (game_reg == GAME_TENNIS) begin
                            rot_next = rot_reg + 3'h1;
                            if (rot_reg == `SERVE_ROTATE - 3'h1) begin
                                rot_next = 3'h0;
                                srv_next = ~srv_reg;
                            end
                        end
                    end
                end
                if ((twoPlayer || game_reg == GAME_TARGET_ONE) &&
                    (sl_next == `SCORE_MAX || sr_next == `SCORE_MAX)) begin
                    st_next  = ST_OVER;
                    win_next = (sr_next == `SCORE_MAX) && (sl_next != `SCORE_MAX);
                end
            end
            default: begin
                st_next = ST_OVER;
            end
        endcase
    end

    // a new selection restarts like a game reset so scores never carry across games
    always_ff @(posedge ref_clk) begin
        if (!rst_n || gameChange) begin
            st_reg   <= ST_WAIT;
            sl_reg   <= 4'h0;
            sr_reg   <= 4'h0;
            srv_reg  <= 1'b0;
            own_reg  <= 1'b0;
            armL_reg <= 1'b0;
            armR_reg <= 1'b0;
            open_reg <= 1'b0;
            win_reg  <= 1'b0;
            rot_reg  <= 3'h0;
            lau_reg  <= 1'b0;
            lr_reg   <= 1'b0;
            ang_reg  <= 3'h0;
        end else begin
            st_reg   <= st_next;
            sl_reg   <= sl_next;
            sr_reg   <= sr_next;
            srv_reg  <= srv_next;
            own_reg  <= own_next;
            armL_reg <= (st_next == ST_WAIT) ? armL_next : 1'b0;
            armR_reg <= (st_next == ST_WAIT) ? armR_next : 1'b0;
            open_reg <= open_next;
            win_reg  <= win_next;
            rot_reg  <= rot_next;
            lau_reg  <= lau_next;
            lr_reg   <= lr_next;
            ang_reg  <= ang_next;
        end
    end

    assign launch          = lau_reg;
    assign launchRight     = lr_reg;
    assign launchAngle     = ang_reg;
    assign ballAtServe     = (st_reg == ST_WAIT);
    assign batsActive      = (st_reg == ST_PLAY);
    assign ballColourRight = own_reg;
    assign serverRight     = srv_reg;
    assign scoreLeft       = sl_reg;
    assign scoreRight      = sr_reg;
    assign gameOver        = (st_reg == ST_OVER);
    assign winnerRight     = win_reg;
endmodule

// ---- verif/ball_game_rule_control_monitor.sv ----
// port assertions for the ball game rule controller
`timescale 1ns/1ps
module ball_game_rule_control_monitor
    import game_rule_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [3:0] strbOut,
    input wire logic [3:0] strbOe,
    input wire logic [7:0] leftPosY,
    input wire logic [7:0] rightPosY,
    input wire game_t      gameSel,
    input wire logic [7:0] leftBatX,
    input wire logic [7:0] rightBatX,
    input wire logic [7:0] leftKeeperY,
    input wire logic [7:0] rightKeeperY,
    input wire logic       launch,
    input wire logic       launchRight,
    input wire logic       ballAtServe,
    input wire logic       batsActive,
    input wire logic       serverRight,
    input wire logic [3:0] scoreLeft,
    input wire logic [3:0] scoreRight,
    input wire logic       gameOver
);
    default clocking mon @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic duel;
    // practice games may sit at 15 without ending
    assign duel = !(gameSel inside {GAME_NONE, GAME_PRACTICE, GAME_BASKET_PRACTICE});
    a_tennis_half: assert property (
        gameSel == GAME_TENNIS && $past(gameSel) == GAME_TENNIS |-> leftBatX <= 8'h7F && rightBatX >= 8'h80)
        else $error("bat outside own half");
    a_launch_serve: assert property (launch |-> $past(ballAtServe) && !ballAtServe && batsActive)
        else $error("launch not from serve wait");
    a_launch_pulse: assert property (launch |=> !launch)
        else $error("launch longer than one cycle");
    a_serve_dir: assert property (
        launch && gameSel inside {GAME_TENNIS, GAME_SOCCER} |-> launchRight == !serverRight)
        else $error("serve heads the wrong way");
    a_keeper_track: assert property (
        gameSel == GAME_HOCKEY && $past(gameSel) == GAME_HOCKEY
        |-> leftKeeperY == $past(leftPosY) && rightKeeperY == $past(rightPosY))
        else $error("keeper not tracking");
    a_strobe_scan: assert property (
        $onehot(strbOe) && strbOut == 4'h0 && (!$changed(strbOe) || strbOe == ($past(strbOe) << 1 | $past(strbOe) >> 3)))
        else $error("strobe scan out of order");
    a_over_frozen: assert property (gameOver |-> !launch && !batsActive)
        else $error("play continues after game over");
    a_stop_at_max: assert property (
        duel && (scoreLeft == 4'hF || scoreRight == 4'hF) |-> ##[0:1] gameOver)
        else $error("game not stopped at 15");
    a_reset_clear: assert property (
        $rose(rst_n) |-> scoreLeft == 4'h0 && scoreRight == 4'h0 && ballAtServe && gameSel == GAME_NONE)
        else $error("reset left state behind");
    c_tennis_launch: cover property (launch && gameSel == GAME_TENNIS);
    c_practice_max: cover property (gameSel == GAME_PRACTICE && scoreRight == 4'hF);
    c_target_hit: cover property (gameSel == GAME_TARGET_TWO && scoreLeft == 4'h1);
endmodule

bind ball_game_rule_control ball_game_rule_control_monitor ball_game_rule_control_monitor_inst (
    .ref_clk, .rst_n, .strbOut, .strbOe, .leftPosY, .rightPosY, .gameSel, .leftBatX, .rightBatX,
    .leftKeeperY, .rightKeeperY, .launch, .launchRight, .ballAtServe, .batsActive, .serverRight,
    .scoreLeft, .scoreRight, .gameOver);

// ---- verif/player_model.sv ----
// players' buttons and the strobe to select wiring
`timescale 1ns/1ps
module player_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] strbOe,
    input  wire logic [3:0] strPick,
    input  wire logic [2:0] selPick,
    output logic      [2:0] selN,
    output logic      [3:0] btnN
);
    // select lines have pull-ups: low only while the wired strobe pulls low
    assign selN = ~(selPick & {3{|(strbOe & strPick)}});
    initial btnN = 4'hF;
    // open buttons float up to the pull-up level
    task automatic press(input int b, input int n);
        @(negedge ref_clk);
        btnN[b] = 1'b0;
        repeat (n) @(negedge ref_clk);
        btnN[b] = 1'b1;
    endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the ball game rule controller
`timescale 1ns/1ps
module testbench
    import game_rule_pkg::*;
;
    logic       ref_clk, rst_n, hitLeft, goalLeft, goalRight, targetStart, onTargetLeft, onTargetRight;
    logic       hitRight, basketMade;
    logic       launch, launchRight, ballAtServe, batsActive, ballColourRight, serverRight, gameOver, winnerRight;
    logic [2:0] selN, selPick, launchAngle;
    logic [3:0] strbOut, strbOe, strPick, btnN, scoreLeft, scoreRight;
    logic [7:0] leftPosX, leftPosY, rightPosX, rightPosY, leftBatX, leftBatY, rightBatX, rightBatY;
    logic [7:0] leftKeeperY, rightKeeperY;
    game_t      gameSel;
    int         n_fail = 0;
    int         compares = 0;
    ball_game_rule_control ball_game_rule_control_inst (
        .ref_clk, .rst_n, .strbOut, .strbOe, .selN, .serveLeftN(btnN[0]), .serveRightN(btnN[1]),
        .shotLeftN(btnN[2]), .shotRightN(btnN[3]), .leftPosX, .leftPosY, .rightPosX, .rightPosY,
        .hitLeft, .hitRight, .goalLeft, .goalRight, .basketMade, .targetStart, .onTargetLeft,
        .onTargetRight, .gameSel, .leftBatX, .leftBatY, .rightBatX, .rightBatY, .leftKeeperY, .rightKeeperY,
        .leftBarrierY(), .rightBarrierY(), .launch, .launchRight, .launchAngle, .ballAtServe, .batsActive,
        .ballColourRight, .serverRight, .scoreLeft, .scoreRight, .gameOver, .winnerRight);
    player_model player_model_inst (.ref_clk, .strbOe, .strPick, .selPick, .selN, .btnN);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // a full scan is four slots of 200 clk, plus the latch edge
    task automatic pick(input logic [3:0] s, input logic [2:0] l, input game_t g);
        strPick = s;
        selPick = l;
        repeat (810) @(negedge ref_clk);
        check(gameSel, g);
    endtask
    task automatic pulse(ref logic sig);
        @(negedge ref_clk);
        sig = 1'b1;
        @(negedge ref_clk);
        sig = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    // a press outlasts the 4000 clk debounce; launch stands one cycle
    task automatic serve(input int b, output logic seen);
        seen = 1'b0;
        fork
            player_model_inst.press(b, 4010);
            repeat (4015) @(posedge ref_clk) #1 if (launch === 1'b1) seen = 1'b1;
        join
    endtask
    task automatic t_reset;
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check(scoreLeft, 4'h0);
        check(scoreRight, 4'h0);
        check(ballAtServe, 1'b1);
        check(gameSel, GAME_NONE);
        $display("reset test done");
    endtask
    task automatic t_select;
        game_t g[10] = '{GAME_TENNIS, GAME_HOCKEY, GAME_SQUASH, GAME_PRACTICE, GAME_SOCCER,
            GAME_BASKETBALL, GAME_BASKET_PRACTICE, GAME_GRIDBALL, GAME_TARGET_ONE, GAME_TARGET_TWO};
        for (int i = 0; i < 10; i++) begin
            pick(4'h1 << (i < 8 ? i / 3 : 3), 3'h1 << (i < 8 ? i % 3 : i - 8), g[i]);
        end
        // third strobe on third select is no game: the old one stays
        pick(4'h4, 3'h4, GAME_TARGET_TWO);
        $display("select test done");
    endtask
    task automatic t_tennis;
        logic seen, srv;
        pick(4'h1, 3'h1, GAME_TENNIS);
        leftPosX = 8'hFF;
        rightPosX = 8'h00;
        repeat (3) @(negedge ref_clk);
        check(leftBatX, 8'h7F);
        check(rightBatX, 8'h80);
        srv = serverRight;
        serve(srv ? 0 : 1, seen);
        check(seen, 1'b0);
        for (int p = 0; p < 5; p++) begin
            serve(srv ? 1 : 0, seen);
            check(seen, 1'b1);
            if (p[0])
                pulse(goalRight);
            else
                pulse(goalLeft);
            // the same button needs a settled release before it counts again
            repeat (4010) @(negedge ref_clk);
        end
        check(scoreRight, 4'h3);
        check(scoreLeft, 4'h2);
        check(serverRight, !srv);
        $display("tennis test done");
    endtask
    task automatic t_hockey;
        logic seen;
        pick(4'h1, 3'h2, GAME_HOCKEY);
        leftPosY = 8'h33;
        rightPosY = 8'hC4;
        repeat (3) @(negedge ref_clk);
        check(leftKeeperY, 8'h33);
        check(rightKeeperY, 8'hC4);
        serve(0, seen);
        check(seen, 1'b0);
        serve(1, seen);
        check(seen, 1'b1);
        $display("hockey test done");
    endtask
    task automatic t_practice;
        logic seen;
        pick(4'h2, 3'h1, GAME_PRACTICE);
        serve(0, seen);
        check(seen, 1'b1);
        check(scoreLeft, 4'h1);
        repeat (15) pulse(hitLeft);
        pulse(hitRight);
        check(scoreRight, 4'hF);
        pick(4'h4, 3'h1, GAME_BASKET_PRACTICE);
        serve(1, seen);
        pulse(basketMade);
        check(scoreLeft, 4'h1);
        $display("practice test done");
    endtask
    task automatic t_target;
        pick(4'h8, 3'h1, GAME_TARGET_ONE);
        repeat (15) pulse(targetStart);
        check(gameOver, 1'b1);
        check(winnerRight, 1'b1);
        pick(4'h8, 3'h2, GAME_TARGET_TWO);
        onTargetLeft = 1'b1;
        onTargetRight = 1'b1;
        pulse(targetStart);
        fork
            player_model_inst.press(2, 4010);
            #250 player_model_inst.press(3, 4010);
        join
        check(scoreLeft, 4'h1);
        check(scoreRight, 4'h0);
        repeat (4010) @(negedge ref_clk);
        pulse(targetStart);
        player_model_inst.press(3, 4010);
        check(scoreRight, 4'h1);
        $display("target test done");
    endtask
    initial begin
        {rst_n, hitLeft, goalLeft, goalRight, targetStart, onTargetLeft, onTargetRight, hitRight, basketMade} = '0;
        {leftPosX, leftPosY, rightPosX, rightPosY} = '0;
        strPick = 4'h0;
        selPick = 3'h0;
        t_reset();
        t_select();
        t_tennis();
        t_hockey();
        t_practice();
        t_target();
        t_reset();
        finish_test();
    end
    // the planned sequence needs about 86000 cycles
    initial begin
        #(95000 * 5);
        n_fail++;
        finish_test();
    end
endmodule
